// File: common/bp_pkg.sv
// Shared constants of the boost PWM sync and protection block.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package bp_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_KHZ = 50000;
  localparam int unsigned N_PHASE = 3;
  localparam int unsigned FS_CODES = 8;
  localparam int unsigned FS_KHZ [FS_CODES] = '{200, 300, 400, 500, 600, 700, 800, 1000};
  localparam int unsigned SYNC_DEB_CYC = 2;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_OVP = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_INV_BIT = 1;
  localparam int unsigned CTRL_FSO_BIT = 2;
  localparam int unsigned CODE7_LSB = 0;
  localparam int unsigned HYST_LSB = 8;
  localparam int unsigned LIM_LSB = 0;
  localparam int unsigned SLOPE_LSB = 8;
  localparam int unsigned FREQ_LSB = 12;
  localparam int unsigned ST_OV_BIT = 0;
  localparam int unsigned ST_REG_LSB = 1;
  localparam int unsigned ST_FSO_BIT = 4;
  localparam int unsigned ST_GATE_LSB = 8;
  localparam int unsigned IRQ_OV_BIT = 0;
  localparam int unsigned IRQ_ILIM_BIT = 1;
  localparam int unsigned IRQ_W = 2;
  // ==========================================================
  // Reset values and bus answers
  localparam logic [6:0] TARGET_RST = 7'h00;
  localparam logic [6:0] TRIP_RST = 7'h7f;
  localparam logic [1:0] HYST_RST = 2'h0;
  localparam logic [1:0] LIM_RST = 2'h3;
  localparam logic [2:0] SLOPE_RST = 3'h0;
  localparam logic [2:0] FREQ_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: common/bp_tick_if.sv
// One-cycle PWM cycle start between a timing source and the gate logic.
// Assumes source and user share clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
interface bp_tick_if;
  logic start;
  modport src (output start);
  modport dst (input start);
endinterface
`default_nettype wire

// File: hw/bp_sync_edge.sv
// Samples, debounces and edge-detects the external switch sync input.
// Assumes the input is asynchronous and slower than 1 MHz.
`timescale 1ns/100ps
`default_nettype none
module bp_sync_edge (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic switch_sync_input_i,
  input wire logic sync_edge_invert_i,
  bp_tick_if.src tick
);
  logic meta_reg;
  logic samp_reg;
  logic hist_reg;
  logic deb_reg;
  logic start_reg;

  // ==========================================================
  // Synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_reg <= 1'b0;
      samp_reg <= 1'b0;
      hist_reg <= 1'b0;
    end else begin
      meta_reg <= switch_sync_input_i;
      samp_reg <= meta_reg;
      hist_reg <= samp_reg;
    end
  end

  // ==========================================================
  // two-cycle debounce
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      deb_reg <= 1'b0;
    end else if (samp_reg == hist_reg) begin
      deb_reg <= samp_reg;
    end
  end

  // ==========================================================
  // selected edge starts cycle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= (samp_reg == hist_reg) && (samp_reg != deb_reg)
                   && (samp_reg != sync_edge_invert_i);
    end
  end

  assign tick.start = start_reg;
endmodule // bp_sync_edge
`default_nettype wire

// File: hw/bp_int_pwm.sv
// Internal fail-safe PWM cycle generator from the system clock.
// Assumes the frequency code is stable or changes between cycles.
`timescale 1ns/100ps
`default_nettype none
module bp_int_pwm #(
  parameter int unsigned PER_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic [2:0] fail_safe_switch_freq_i,
  bp_tick_if.src tick
);
  logic [PER_W-1:0] per_tab [bp_pkg::FS_CODES];
  logic [PER_W-1:0] cnt_reg;
  logic start_reg;

  // ==========================================================
  // period per frequency code
  for (genvar i = 0; i < bp_pkg::FS_CODES; i++) begin : g_tab
    assign per_tab[i] = PER_W'(bp_pkg::CLK_KHZ / bp_pkg::FS_KHZ[i] - 1);
  end

  // ==========================================================
  // divider on system clock
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_reg <= '0;
      start_reg <= 1'b0;
    end else if (cnt_reg >= per_tab[fail_safe_switch_freq_i]) begin
      cnt_reg <= '0;
      start_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + PER_W'(1);
      start_reg <= 1'b0;
    end
  end

  assign tick.start = start_reg;
endmodule // bp_int_pwm
`default_nettype wire

// File: hw/bp_top.sv
// Boost gate PWM timing, current limit and overvoltage protection.
// Assumes analog comparators outside, asynchronous to clk_sys_i.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module bp_top #(
  parameter int unsigned N_PHASE = bp_pkg::N_PHASE
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic switch_sync_input_i,
  input wire logic ov_above_trip_i,
  input wire logic ov_below_rearm_i,
  input wire logic [N_PHASE-1:0] peak_current_cmp_i,
  input wire logic [N_PHASE-1:0] current_limit_cmp_i,
  output logic [N_PHASE-1:0] gate_o,
  output logic [6:0] boost_target_code_o,
  output logic [6:0] overvoltage_trip_code_o,
  output logic [1:0] overvoltage_rearm_hysteresis_o,
  output logic [2*N_PHASE-1:0] peak_current_limit_code_o,
  output logic [2:0] slope_comp_code_o,
  output logic irq_o
);
  localparam int unsigned LW = 2 * N_PHASE;

  logic enable_reg;
  logic sync_edge_invert_reg;
  logic fail_safe_mode_reg;
  logic [6:0] target_reg;
  logic [6:0] trip_reg;
  logic [1:0] hyst_reg;
  logic [LW-1:0] limit_reg;
  logic [2:0] slope_reg;
  logic [2:0] freq_reg;
  logic [bp_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [bp_pkg::IRQ_W-1:0] irq_mask_reg;
  logic ov_flag_reg;
  logic ov_lock_reg;
  logic [N_PHASE-1:0] gate_reg;
  logic irq_reg;

  logic [1:0] ova_sync_reg;
  logic [1:0] ovb_sync_reg;
  logic [N_PHASE-1:0] pk_meta_reg;
  logic [N_PHASE-1:0] pk_reg;
  logic [N_PHASE-1:0] lim_meta_reg;
  logic [N_PHASE-1:0] lim_reg;

  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic do_write;
  logic do_read;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rd_next;
  logic rd_hit;
  logic wr_hit;
  logic status_read;
  logic cycle_start;
  logic ov_trip;
  logic ov_rearm;
  logic ilim_evt;

  bp_tick_if ext_tick ();
  bp_tick_if int_tick ();

  // ==========================================================
  // Timing sources
  // external sync conditioning
  bp_sync_edge u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .switch_sync_input_i(switch_sync_input_i),
    .sync_edge_invert_i(sync_edge_invert_reg),
    .tick(ext_tick.src)
  );

  bp_int_pwm u_int (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .run_i(fail_safe_mode_reg),
    .fail_safe_switch_freq_i(freq_reg),
    .tick(int_tick.src)
  );

  assign cycle_start = fail_safe_mode_reg ? int_tick.start : ext_tick.start;

  // ==========================================================
  // Comparator synchronisers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ova_sync_reg <= 2'h0;
      ovb_sync_reg <= 2'h0;
      pk_meta_reg <= '0;
      pk_reg <= '0;
      lim_meta_reg <= '0;
      lim_reg <= '0;
    end else begin
      ova_sync_reg <= {ova_sync_reg[0], ov_above_trip_i};
      ovb_sync_reg <= {ovb_sync_reg[0], ov_below_rearm_i};
      pk_meta_reg <= peak_current_cmp_i;
      pk_reg <= pk_meta_reg;
      lim_meta_reg <= current_limit_cmp_i;
      lim_reg <= lim_meta_reg;
    end
  end

  assign ov_trip = ova_sync_reg[1];
  assign ov_rearm = ovb_sync_reg[1] && !ov_trip;
  assign ilim_evt = enable_reg && (|(gate_reg & lim_reg));

  // ==========================================================
  // Overvoltage lock
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ov_lock_reg <= 1'b0;
    end else if (ov_trip) begin
      ov_lock_reg <= 1'b1;
    end else if (ov_rearm) begin
      ov_lock_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ov_flag_reg <= 1'b0;
    end else if (ov_trip) begin
      ov_flag_reg <= 1'b1;
    end else if (status_read && ov_rearm) begin
      ov_flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Gate per phase
  for (genvar p = 0; p < N_PHASE; p++) begin : g_phase
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        gate_reg[p] <= 1'b0;
      end else if (!enable_reg || ov_lock_reg || ov_trip) begin
        gate_reg[p] <= 1'b0;
      end else if (pk_reg[p] || lim_reg[p]) begin
        // first of peak or limit clears
        gate_reg[p] <= 1'b0;
      end else if (cycle_start) begin
        gate_reg[p] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Interrupts
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_stat_reg <= '0;
    end else begin
      for (int i = 0; i < bp_pkg::IRQ_W; i++) begin
        if ((i == bp_pkg::IRQ_OV_BIT && ov_trip && !ov_lock_reg)
            || (i == bp_pkg::IRQ_ILIM_BIT && ilim_evt)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_hit && waddr_reg == bp_pkg::OFS_IRQ_STAT && wval[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wmask[8*b +: 8] = {8{wstrb_reg[b]}};
  end
  assign wval = wdata_reg & wmask;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_hit = do_write && (waddr_reg == bp_pkg::OFS_CTRL
    || waddr_reg == bp_pkg::OFS_TARGET || waddr_reg == bp_pkg::OFS_OVP
    || waddr_reg == bp_pkg::OFS_LIMIT || waddr_reg == bp_pkg::OFS_IRQ_STAT
    || waddr_reg == bp_pkg::OFS_IRQ_MASK || waddr_reg == bp_pkg::OFS_STATUS);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= bp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? bp_pkg::RESP_OKAY : bp_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Setting registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      enable_reg <= 1'b0;
      sync_edge_invert_reg <= 1'b0;
      fail_safe_mode_reg <= 1'b0;
      target_reg <= bp_pkg::TARGET_RST;
      trip_reg <= bp_pkg::TRIP_RST;
      hyst_reg <= bp_pkg::HYST_RST;
      limit_reg <= {N_PHASE{bp_pkg::LIM_RST}};
      slope_reg <= bp_pkg::SLOPE_RST;
      freq_reg <= bp_pkg::FREQ_RST;
      irq_mask_reg <= '0;
    end else if (wr_hit) begin
      if (waddr_reg == bp_pkg::OFS_CTRL && wstrb_reg[0]) begin
        enable_reg <= wdata_reg[bp_pkg::CTRL_EN_BIT];
        sync_edge_invert_reg <= wdata_reg[bp_pkg::CTRL_INV_BIT];
        fail_safe_mode_reg <= wdata_reg[bp_pkg::CTRL_FSO_BIT];
      end
      if (waddr_reg == bp_pkg::OFS_TARGET && wstrb_reg[0]) begin
        target_reg <= wdata_reg[bp_pkg::CODE7_LSB +: 7];
      end
      if (waddr_reg == bp_pkg::OFS_OVP) begin
        if (wstrb_reg[0]) begin
          trip_reg <= wdata_reg[bp_pkg::CODE7_LSB +: 7];
        end
        if (wstrb_reg[1]) begin
          hyst_reg <= wdata_reg[bp_pkg::HYST_LSB +: 2];
        end
      end
      if (waddr_reg == bp_pkg::OFS_LIMIT) begin
        if (wstrb_reg[0]) begin
          limit_reg <= wdata_reg[bp_pkg::LIM_LSB +: LW];
        end
        if (wstrb_reg[1]) begin
          slope_reg <= wdata_reg[bp_pkg::SLOPE_LSB +: 3];
          freq_reg <= wdata_reg[bp_pkg::FREQ_LSB +: 3];
        end
      end
      if (waddr_reg == bp_pkg::OFS_IRQ_MASK && wstrb_reg[0]) begin
        irq_mask_reg <= wval[bp_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign do_read = s_axi_arvalid && !rvalid_reg;
  assign status_read = do_read && ({s_axi_araddr[7:2], 2'b00} == bp_pkg::OFS_STATUS);

  always_comb begin
    rd_next = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      bp_pkg::OFS_CTRL: begin
        rd_next[bp_pkg::CTRL_EN_BIT] = enable_reg;
        rd_next[bp_pkg::CTRL_INV_BIT] = sync_edge_invert_reg;
        rd_next[bp_pkg::CTRL_FSO_BIT] = fail_safe_mode_reg;
      end
      bp_pkg::OFS_TARGET: begin
        rd_next[bp_pkg::CODE7_LSB +: 7] = target_reg;
      end
      bp_pkg::OFS_OVP: begin
        rd_next[bp_pkg::CODE7_LSB +: 7] = trip_reg;
        rd_next[bp_pkg::HYST_LSB +: 2] = hyst_reg;
      end
      bp_pkg::OFS_LIMIT: begin
        rd_next[bp_pkg::LIM_LSB +: LW] = limit_reg;
        rd_next[bp_pkg::SLOPE_LSB +: 3] = slope_reg;
        rd_next[bp_pkg::FREQ_LSB +: 3] = freq_reg;
      end
      bp_pkg::OFS_STATUS: begin
        rd_next[bp_pkg::ST_OV_BIT] = ov_flag_reg;
        rd_next[bp_pkg::ST_REG_LSB +: N_PHASE] =
          {N_PHASE{enable_reg && !ov_lock_reg && !ov_trip}};
        rd_next[bp_pkg::ST_FSO_BIT] = fail_safe_mode_reg;
        rd_next[bp_pkg::ST_GATE_LSB +: N_PHASE] = gate_reg;
      end
      bp_pkg::OFS_IRQ_STAT: begin
        rd_next[bp_pkg::IRQ_W-1:0] = irq_stat_reg;
      end
      bp_pkg::OFS_IRQ_MASK: begin
        rd_next[bp_pkg::IRQ_W-1:0] = irq_mask_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= bp_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_next;
      rresp_reg <= rd_hit ? bp_pkg::RESP_OKAY : bp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign gate_o = gate_reg;
  assign boost_target_code_o = target_reg;
  assign overvoltage_trip_code_o = trip_reg;
  assign overvoltage_rearm_hysteresis_o = hyst_reg;
  assign peak_current_limit_code_o = limit_reg;
  assign slope_comp_code_o = slope_reg;
  assign irq_o = irq_reg;
endmodule // bp_top
`default_nettype wire

// File: tb/bp_top_sva.sv
// Port checker for the boost PWM block.
// Bound onto bp_top; single clk_sys_i domain.
`timescale 1ns/100ps
`default_nettype none
module bp_top_sva #(
  parameter int unsigned N_PHASE = 3
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ov_above_trip_i,
  input wire logic ov_below_rearm_i,
  input wire logic [N_PHASE-1:0] peak_current_cmp_i,
  input wire logic [N_PHASE-1:0] current_limit_cmp_i,
  input wire logic [N_PHASE-1:0] gate_o
);
  // ========
  // Properties
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_trip;
    (ov_above_trip_i && !ov_below_rearm_i) [*4];
  endsequence
  sequence s_no_rearm;
    (!ov_below_rearm_i) [*4];
  endsequence
  AST_RST_GATE: assert property (disable iff (1'b0)
    sys_rst_i |=> gate_o == '0) else $error("Gate on after reset");
  AST_OV_OFF: assert property (
    s_trip |=> gate_o == '0) else $error("Gate on during trip");
  AST_OV_HOLD: assert property (
    s_trip ##1 s_no_rearm |=> gate_o == '0) else $error("Gate on before rearm");
  AST_LIM_OFF: assert property (
    current_limit_cmp_i[0] [*4] |=> !gate_o[0]) else $error("Gate on over limit");
  AST_PEAK_OFF: assert property (
    peak_current_cmp_i[N_PHASE-1] [*4] |=> !gate_o[N_PHASE-1]) else $error("Gate on at peak");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("No write response");
  AST_R_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("No read data");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped");
endmodule // bp_top_sva
bind bp_top bp_top_sva #(.N_PHASE(N_PHASE)) u_sva (
  .clk_sys_i, .sys_rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .ov_above_trip_i, .ov_below_rearm_i,
  .peak_current_cmp_i, .current_limit_cmp_i, .gate_o
);
`default_nettype wire

// File: tb/bp_sync_src.sv
// Sync clock source standing in for the external controller.
// Pin is driven low by the model between bursts.
`timescale 1ns/100ps
`default_nettype none
module bp_sync_src (
  input wire logic run_i,
  input wire logic glitch_i,
  input wire logic [15:0] half_ns_i,
  output logic switch_sync_input_o
);
  // ========
  // Pin drive
  // period 1 us min
  initial begin
    switch_sync_input_o = 1'b0;
    forever begin
      wait (run_i || glitch_i);
      if (run_i) begin
        #((half_ns_i < 16'd500) ? 500 : half_ns_i) switch_sync_input_o = 1'b1;
        #((half_ns_i < 16'd500) ? 500 : half_ns_i) switch_sync_input_o = 1'b0;
      end else begin
        #7 switch_sync_input_o = 1'b1;
        #15 switch_sync_input_o = 1'b0;
        wait (!glitch_i);
      end
    end
  end
endmodule // bp_sync_src
`default_nettype wire

// File: tb/bp_top_test.sv
// Self-checking bench for the boost PWM block.
// Drives AXI4-Lite, comparators and the sync source model.
`timescale 1ns/100ps
`default_nettype none
module bp_top_test;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ov_above = 1'b0, ov_below = 1'b1;
  logic sync_run = 1'b0, glitch = 1'b0, auto_pk = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, sw_sync;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [15:0] half_ns = 16'd517;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [2:0] peak = 3'h0, pk_man = 3'h0, lim = 3'h0, gate, slope;
  logic [1:0] bresp, rresp, hyst;
  logic [6:0] tgt, trip;
  logic [5:0] limc;
  int n_mismatch = 0, tests_run = 0, i;
  longint t0;
  bp_top dut (
    .clk_sys_i, .sys_rst_i, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .switch_sync_input_i(sw_sync), .ov_above_trip_i(ov_above), .ov_below_rearm_i(ov_below),
    .peak_current_cmp_i(peak), .current_limit_cmp_i(lim), .gate_o(gate),
    .boost_target_code_o(tgt), .overvoltage_trip_code_o(trip),
    .overvoltage_rearm_hysteresis_o(hyst),
    .peak_current_limit_code_o(limc), .slope_comp_code_o(slope), .irq_o(irq)
  );
  bp_sync_src u_src (.run_i(sync_run), .glitch_i(glitch), .half_ns_i(half_ns),
    .switch_sync_input_o(sw_sync));
  // ========
  // Helpers
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    peak <= auto_pk ? gate : pk_man;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic edge_wait(input logic f);
    if (f) @(negedge sw_sync);
    else @(posedge sw_sync);
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er = 2'h0);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'b0;
      rready <= rvalid && !rready;
    end while (!(rvalid && rready));
    chk(rdata & m, e);
    chk(rresp, er);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end
  // ========
  // Scenarios
  initial begin
    v = $urandom(32'h4750);
    tick(2);
    sys_rst_i <= 1'b0;
    tick(1);
    chk(gate, 3'h0);
    rdc(bp_pkg::OFS_CTRL, 32'h7, 32'h0);
    rdc(bp_pkg::OFS_TARGET, 32'h7f, 32'h0);
    rdc(bp_pkg::OFS_OVP, 32'h37f, 32'h7f);
    rdc(bp_pkg::OFS_LIMIT, 32'h773f, 32'h3f);
    rdc(8'h1c, 32'hffffffff, 32'h0, bp_pkg::RESP_SLVERR);
    wr(8'h1c, 32'hffffffff, bp_pkg::RESP_SLVERR);
    for (i = 0; i < 8; i++) begin
      v = $urandom;
      v[10:8] = i[2:0];
      wr(bp_pkg::OFS_LIMIT, v);
      wr(bp_pkg::OFS_TARGET, v);
      chk({tgt, slope, limc}, {v[6:0], v[10:8], v[5:0]});
      wr(bp_pkg::OFS_OVP, v);
      chk({trip, hyst}, {v[6:0], v[9:8]});
    end
    sync_run <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(bp_pkg::OFS_CTRL, 32'h1 | (i << 1));
      edge_wait(i[0]);
      tick(7);
      chk(gate, 3'h7);
      pk_man <= 3'h7;
      tick(5);
      chk(gate, 3'h0);
      pk_man <= 3'h0;
      edge_wait(!i[0]);
      tick(7);
      chk(gate, 3'h0);
    end
    edge_wait(1'b1);
    tick(7);
    lim <= 3'h1;
    tick(5);
    chk(gate, 3'h6);
    lim <= 3'h0;
    chk(irq, 1'b0);
    wr(bp_pkg::OFS_IRQ_MASK, 32'h2);
    tick(2);
    chk(irq, 1'b1);
    wr(bp_pkg::OFS_IRQ_STAT, 32'h2);
    tick(2);
    chk(irq, 1'b0);
    ov_below <= 1'b0;
    ov_above <= 1'b1;
    tick(6);
    chk(gate, 3'h0);
    rdc(bp_pkg::OFS_STATUS, 32'h1f, 32'h01);
    ov_above <= 1'b0;
    half_ns <= 16'd1013;
    tick(120);
    chk(gate, 3'h0);
    rdc(bp_pkg::OFS_STATUS, 32'h1, 32'h1);
    rdc(bp_pkg::OFS_IRQ_STAT, 32'h3, 32'h1);
    ov_below <= 1'b1;
    tick(4);
    rdc(bp_pkg::OFS_STATUS, 32'h1, 32'h1);
    rdc(bp_pkg::OFS_STATUS, 32'h1f, 32'h0e);
    edge_wait(1'b1);
    tick(7);
    chk(gate, 3'h7);
    auto_pk <= 1'b1;
    sync_run <= 1'b0;
    wr(bp_pkg::OFS_CTRL, 32'h1);
    tick(110);
    glitch <= 1'b1;
    repeat (10) begin
      tick(1);
      chk(gate, 3'h0);
    end
    glitch <= 1'b0;
    for (i = 0; i < bp_pkg::FS_CODES; i++) begin
      wr(bp_pkg::OFS_LIMIT, 32'h3f | (i << bp_pkg::FREQ_LSB));
      wr(bp_pkg::OFS_CTRL, 32'h5);
      @(posedge gate[0]);
      @(posedge gate[0]);
      t0 = $time;
      @(posedge gate[0]);
      chk(32'(($time - t0) / 20), bp_pkg::CLK_KHZ / bp_pkg::FS_KHZ[i]);
    end
    rdc(bp_pkg::OFS_STATUS, 32'h10, 32'h10);
    end_sim();
  end
endmodule // bp_top_test
`default_nettype wire
